/* src/slot_prescaler.sv */
/*
 * 18-bit tunable prescaler for the slot timer. it counts up on each
 * system timer tick by a step chosen by the interval select, and
 * restarts when it reaches the prescaler value times 1024.
 * assumes: timerTick is a one-cycle enable pulse on ref_clk.
 */
`timescale 1ns/1ps
module slot_prescaler (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic timerTick,
   input wire logic run,
   input wire logic [1:0] intervalSelect,
   input wire logic [7:0] prescalerValue,
   output logic slotEdge
);

   // ************************************************************
   // step and terminal value
   // ************************************************************
   logic [17:0] preCount_reg; // prescaler counter, null state is zero
   logic [17:0] preCount_next;
   logic slotEdge_next;
   logic [8:0] step; // count added per tick, 1024 over the multiplier
   logic [8:0] effectiveValue; // zero in the value register means 256
   logic [18:0] limit; // value fills the 8 top bits of the counter
   logic [18:0] sum;
   logic reachLimit;

   // a smaller multiplier is a larger step, so the terminal stays put
   assign step = (intervalSelect == 2'h0) ? slot_timer_pkg::STEP_SEL0 :
                 (intervalSelect == 2'h1) ? slot_timer_pkg::STEP_SEL1 :
                 (intervalSelect == 2'h2) ? slot_timer_pkg::STEP_SEL2 :
                 slot_timer_pkg::STEP_SEL3;
   assign effectiveValue = (prescalerValue == 8'h00) ? slot_timer_pkg::PRESCALER_ZERO_AS :
                           {1'b0, prescalerValue};
   assign limit = {effectiveValue, 10'h000};
   assign sum = {1'b0, preCount_reg} + {10'h000, step};
   // >= guards a value lowered mid-count, which would otherwise overrun
   assign reachLimit = sum >= limit;

   // next state: events only ever happen on a system tick
   always_comb begin
      preCount_next = preCount_reg;
      slotEdge_next = 1'b0;
      if (!run) begin
         preCount_next = 18'h00000; // held in null state while stopped
      end else if (timerTick) begin
         if (reachLimit) begin
            preCount_next = 18'h00000;
            slotEdge_next = 1'b1;
         end else begin
            preCount_next = sum[17:0];
         end
      end
   end

   // ************************************************************
   // state
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         preCount_reg <= 18'h00000;
         slotEdge <= 1'b0;
      end else begin
         preCount_reg <= preCount_next;
         slotEdge <= slotEdge_next;
      end
   end

endmodule

/* src/slot_timer.sv */
/*
 * 8-bit down-counting slot timer with its control, prescaler value
 * and count registers on the special function register port.
 * assumes: the sfr port is synchronous to ref_clk, one access per
 * cycle; timerTick is a one-cycle pulse at the system tick rate;
 * wakeFromDeepSleep pulses when the chip leaves the deepest modes.
 */
//
// Contract
// - 8-bit count, minus one per slot edge, readable
// - count reaching zero sets expiry flag
// - mode bit clear: count stops at zero
// - mode bit set: zero wraps to 0xFF
// - enable gates irq flag and interrupt request
// - count write loads at once
// - write on a slot edge stores value minus one
// - 18-bit prescaler aligned to system tick
// - value register gives prescaler top eight bits
// - interval select sets rate; restart at maximum
// - multipliers 64, 128, 256, 1024 per code
// - prescaler value zero acts as 256
// - one dma trigger per expiry flag set
// - registers reset on wake from deep sleep
// - expiry flag: write one ignored, zero clears
// - mode clear: generator runs while count non-zero
// - mode set: free-running, starts from null; a generator already running keeps its phase
//
`timescale 1ns/1ps
module slot_timer (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic timerTick,
   input wire logic wakeFromDeepSleep,
   input wire logic systemIrqEnable,
   input wire logic irqFlagClear,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrWriteData,
   output logic [7:0] sfrReadData,
   output logic timerIrqFlag,
   output logic irqRequest,
   output logic expiryDmaTrigger
);

   // ************************************************************
   // register state
   // ************************************************************
   logic [7:0] slotCount_reg; // timer count
   logic [7:0] slotCount_next;
   logic [7:0] prescalerValue_reg; // prescaler terminal top bits
   logic [7:0] prescalerValue_next;
   logic expiryFlag_reg; // sticky, cleared only by a zero write, a reset or a wake
   logic expiryFlag_next;
   logic irqEnable_reg; // local interrupt enable, one enables
   logic irqEnable_next;
   logic reservedHigh_reg; // plain storage, software keeps it zero
   logic reservedHigh_next;
   logic reservedLow_reg; // plain storage, software keeps it zero
   logic reservedLow_next;
   logic tickGenMode_reg; // tick generator mode
   logic tickGenMode_next;
   logic [1:0] intervalSelect_reg; // prescaler rate select
   logic [1:0] intervalSelect_next;

   // output next values
   logic [7:0] sfrReadData_next;
   logic timerIrqFlag_next;
   logic irqRequest_next;
   logic expiryDmaTrigger_next;

   // ************************************************************
   // reset and access decode
   // ************************************************************
   // the wake pulse puts every register back as a reset would
   logic localReset;
   assign localReset = !resetn || wakeFromDeepSleep;

   // prescaler reset mirrors the register reset so it restarts clean
   logic prescalerResetn;
   assign prescalerResetn = !localReset;

   logic countSelect; // address hits the count register
   logic prescalerSelect; // address hits the prescaler value
   logic controlSelect; // address hits the control register
   assign countSelect = sfrAddr == slot_timer_pkg::SLOT_COUNT_ADDR;
   assign prescalerSelect = sfrAddr == slot_timer_pkg::PRESCALER_VALUE_ADDR;
   assign controlSelect = sfrAddr == slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR;

   logic countWrite;
   logic prescalerWrite;
   logic controlWrite;
   assign countWrite = sfrWrite && countSelect;
   assign prescalerWrite = sfrWrite && prescalerSelect;
   assign controlWrite = sfrWrite && controlSelect;

   // ************************************************************
   // tick generator
   // ************************************************************
   logic countIsZero;
   assign countIsZero = slotCount_reg == slot_timer_pkg::COUNT_ZERO;

   // stopped at zero in one-shot mode; stopping drops the prescaler
   // to null, so the next start is from null as well
   // in free-running mode a generator already running keeps its phase,
   // a stopped one leaves null, since stop forced null
   logic generatorRun;
   assign generatorRun = tickGenMode_reg || !countIsZero;

   logic slotEdge; // one-cycle active edge of the prescaled clock

   // the prescaler only moves on system ticks
   slot_prescaler prescaler (
      .ref_clk(ref_clk),
      .resetn(prescalerResetn),
      .timerTick(timerTick),
      .run(generatorRun),
      .intervalSelect(intervalSelect_reg),
      .prescalerValue(prescalerValue_reg),
      .slotEdge(slotEdge)
   );

   // ************************************************************
   // count path
   // ************************************************************
   logic [7:0] writeMinusOne; // written value decremented
   logic [7:0] countMinusOne; // current count decremented
   assign writeMinusOne = sfrWriteData - slot_timer_pkg::COUNT_ONE;
   assign countMinusOne = slotCount_reg - slot_timer_pkg::COUNT_ONE;

   // zero at the edge: wrap in free-running mode, hold otherwise
   logic [7:0] countAtZero;
   assign countAtZero = tickGenMode_reg ? slot_timer_pkg::COUNT_TOP :
                        slot_timer_pkg::COUNT_ZERO;

   // the count reaches zero on a slot edge, through a plain decrement
   // or through a write that lands on the edge with the value one
   logic reachZero;
   assign reachZero = slotEdge && (countWrite ? (sfrWriteData == slot_timer_pkg::COUNT_ONE) :
                      (slotCount_reg == slot_timer_pkg::COUNT_ONE));

   // next count value
   always_comb begin
      slotCount_next = slotCount_reg;
      if (countWrite) begin
         // a write wins over the edge but still sees the decrement
         if (slotEdge) begin
            slotCount_next = writeMinusOne;
         end else begin
            slotCount_next = sfrWriteData;
         end
      end else if (slotEdge) begin
         if (countIsZero) begin
            slotCount_next = countAtZero;
         end else begin
            slotCount_next = countMinusOne;
         end
      end
   end

   // ************************************************************
   // prescaler value register
   // ************************************************************
   // a new value takes effect on the next tick; the prescaler
   // compares with >= so a lowered value cannot be overrun
   always_comb begin
      prescalerValue_next = prescalerValue_reg;
      if (prescalerWrite) begin
         prescalerValue_next = sfrWriteData;
      end
   end

   // ************************************************************
   // control register
   // ************************************************************
   always_comb begin
      irqEnable_next = irqEnable_reg;
      reservedHigh_next = reservedHigh_reg;
      reservedLow_next = reservedLow_reg;
      tickGenMode_next = tickGenMode_reg;
      intervalSelect_next = intervalSelect_reg;
      if (controlWrite) begin
         irqEnable_next = sfrWriteData[slot_timer_pkg::IRQ_ENABLE_BIT];
         // stored as written; software is expected to keep them zero
         reservedHigh_next = sfrWriteData[slot_timer_pkg::RESERVED_HIGH_BIT];
         reservedLow_next = sfrWriteData[slot_timer_pkg::RESERVED_LOW_BIT];
         tickGenMode_next = sfrWriteData[slot_timer_pkg::TICK_GEN_MODE_BIT];
         intervalSelect_next = sfrWriteData[slot_timer_pkg::INTERVAL_SELECT_MSB:
                                            slot_timer_pkg::INTERVAL_SELECT_LSB];
      end
   end

   // expiry flag: hardware set beats a software clear in the same cycle
   logic expiryClear;
   assign expiryClear = controlWrite && !sfrWriteData[slot_timer_pkg::EXPIRY_FLAG_BIT];

   always_comb begin
      expiryFlag_next = expiryFlag_reg;
      if (reachZero) begin
         expiryFlag_next = 1'b1;
      end else if (expiryClear) begin
         expiryFlag_next = 1'b0; // writing one is simply ignored
      end
   end

   // ************************************************************
   // interrupt flag, request and dma trigger
   // ************************************************************
   // the flag follows each expiry set while the local enable is one;
   // the request also needs the system-wide enable
   always_comb begin
      timerIrqFlag_next = timerIrqFlag;
      if (reachZero && irqEnable_reg) begin
         timerIrqFlag_next = 1'b1;
      end else if (irqFlagClear) begin
         timerIrqFlag_next = 1'b0;
      end
   end

   assign irqRequest_next = timerIrqFlag_next && irqEnable_reg && systemIrqEnable;

   // one pulse per set event, also when the flag was still standing
   assign expiryDmaTrigger_next = reachZero;

   // ************************************************************
   // read path
   // ************************************************************
   // bit 7 reads zero; it has no storage, so a one written there is dropped
   logic [7:0] controlReadValue;
   assign controlReadValue = {1'b0, expiryFlag_reg, reservedHigh_reg, irqEnable_reg,
                              reservedLow_reg, tickGenMode_reg, intervalSelect_reg};

   // unmapped addresses answer zero
   logic [7:0] readMux;
   assign readMux = countSelect ? slotCount_reg :
                    prescalerSelect ? prescalerValue_reg :
                    controlSelect ? controlReadValue :
                    slot_timer_pkg::READ_UNMAPPED;

   // read data is registered, so it trails the read strobe one cycle
   assign sfrReadData_next = sfrRead ? readMux : sfrReadData;

   // ************************************************************
   // register update
   // ************************************************************
   // all registers and outputs share the reset, wake included
   always_ff @(posedge ref_clk) begin
      if (localReset) begin
         slotCount_reg <= slot_timer_pkg::COUNT_RESET;
         prescalerValue_reg <= slot_timer_pkg::PRESCALER_RESET;
         expiryFlag_reg <= slot_timer_pkg::CONTROL_RESET[slot_timer_pkg::EXPIRY_FLAG_BIT];
         irqEnable_reg <= slot_timer_pkg::CONTROL_RESET[slot_timer_pkg::IRQ_ENABLE_BIT];
         reservedHigh_reg <= slot_timer_pkg::CONTROL_RESET[slot_timer_pkg::RESERVED_HIGH_BIT];
         reservedLow_reg <= slot_timer_pkg::CONTROL_RESET[slot_timer_pkg::RESERVED_LOW_BIT];
         tickGenMode_reg <= slot_timer_pkg::CONTROL_RESET[slot_timer_pkg::TICK_GEN_MODE_BIT];
         intervalSelect_reg <= slot_timer_pkg::CONTROL_RESET[1:0];
      end else begin
         slotCount_reg <= slotCount_next;
         prescalerValue_reg <= prescalerValue_next;
         expiryFlag_reg <= expiryFlag_next;
         irqEnable_reg <= irqEnable_next;
         reservedHigh_reg <= reservedHigh_next;
         reservedLow_reg <= reservedLow_next;
         tickGenMode_reg <= tickGenMode_next;
         intervalSelect_reg <= intervalSelect_next;
      end
   end

   // outputs come straight from flops
   always_ff @(posedge ref_clk) begin
      if (localReset) begin
         sfrReadData <= slot_timer_pkg::READ_UNMAPPED;
         timerIrqFlag <= 1'b0;
         irqRequest <= 1'b0;
         expiryDmaTrigger <= 1'b0;
      end else begin
         sfrReadData <= sfrReadData_next;
         timerIrqFlag <= timerIrqFlag_next;
         irqRequest <= irqRequest_next;
         expiryDmaTrigger <= expiryDmaTrigger_next;
      end
   end

endmodule

/* src/slot_timer_pkg.sv */
/*
 * constants shared by the slot timer and its prescaler: register
 * addresses, field positions, reset values and prescaler figures.
 * assumes: 8-bit special function register space, 8-bit data.
 */
package slot_timer_pkg;

   // ************************************************************
   // register addresses in the special function register space
   // ************************************************************
   localparam logic [7:0] SLOT_COUNT_ADDR = 8'h9C;
   localparam logic [7:0] PRESCALER_VALUE_ADDR = 8'h9D;
   localparam logic [7:0] SLOT_TIMER_CONTROL_ADDR = 8'h9E;

   // ************************************************************
   // control register field positions
   // ************************************************************
   localparam int EXPIRY_FLAG_BIT = 6;
   localparam int RESERVED_HIGH_BIT = 5;
   localparam int IRQ_ENABLE_BIT = 4;
   localparam int RESERVED_LOW_BIT = 3;
   localparam int TICK_GEN_MODE_BIT = 2;
   localparam int INTERVAL_SELECT_MSB = 1;
   localparam int INTERVAL_SELECT_LSB = 0;

   // ************************************************************
   // values after reset and count limits
   // ************************************************************
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] PRESCALER_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [7:0] COUNT_ONE = 8'h01;
   localparam logic [7:0] COUNT_TOP = 8'hFF;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ************************************************************
   // prescaler figures
   // ************************************************************
   localparam int PRESCALER_WIDTH = 18;
   localparam int PRESCALER_LOW_BITS = 10;
   localparam int MULT_SEL0 = 64;
   localparam int MULT_SEL1 = 128;
   localparam int MULT_SEL2 = 256;
   localparam int MULT_SEL3 = 1024;
   localparam logic [8:0] PRESCALER_ZERO_AS = 9'h100;
   localparam logic [8:0] STEP_SEL0 = 9'(MULT_SEL3 / MULT_SEL0);
   localparam logic [8:0] STEP_SEL1 = 9'(MULT_SEL3 / MULT_SEL1);
   localparam logic [8:0] STEP_SEL2 = 9'(MULT_SEL3 / MULT_SEL2);
   localparam logic [8:0] STEP_SEL3 = 9'(MULT_SEL3 / MULT_SEL3);

endpackage

/* tb/slot_timer_assertions.sv */
/*
 * checker for the slot timer: timing relations between the sfr port,
 * the interrupt outputs and the dma trigger, seen at the top ports.
 * assumes: bound to slot_timer; one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module slot_timer_assertions (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic timerTick,
   input wire logic wakeFromDeepSleep,
   input wire logic systemIrqEnable,
   input wire logic irqFlagClear,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrWriteData,
   input wire logic [7:0] sfrReadData,
   input wire logic timerIrqFlag,
   input wire logic irqRequest,
   input wire logic expiryDmaTrigger
);
   // ************************************************************
   // decode helpers and properties, all on ref_clk
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire logic unmappedRead; // read outside the three timer registers
   wire logic prescalerWr; // write to the prescaler value register
   wire logic prescalerRd; // read of the prescaler value register
   wire logic controlWr; // write to the control register
   wire logic controlRd; // read of the control register
   assign unmappedRead = sfrRead && (sfrAddr < 8'h9C || sfrAddr > 8'h9E);
   assign prescalerWr = sfrWrite && sfrAddr == 8'h9D;
   assign prescalerRd = sfrRead && sfrAddr == 8'h9D;
   assign controlWr = sfrWrite && sfrAddr == 8'h9E;
   assign controlRd = sfrRead && sfrAddr == 8'h9E;

   a_dma_single_pulse: assert property (expiryDmaTrigger |=> !expiryDmaTrigger)
      else $error("dma trigger longer than one cycle");
   a_irq_request_gate: assert property (irqRequest |-> timerIrqFlag && $past(systemIrqEnable))
      else $error("interrupt request without flag and system enable");
   a_flag_with_dma: assert property ($rose(timerIrqFlag) |-> expiryDmaTrigger)
      else $error("irq flag set without an expiry event");
   a_request_follows_flag: assert property ($rose(timerIrqFlag) && $past(systemIrqEnable) |-> irqRequest)
      else $error("irq flag set but no request while enabled");
   a_flag_clear_works: assert property (irqFlagClear && !wakeFromDeepSleep |=> !timerIrqFlag || expiryDmaTrigger)
      else $error("irq flag survived a clear");
   // the flag is sticky: only a clear or a wake may drop it
   a_flag_stays_set: assert property (timerIrqFlag && !irqFlagClear && !wakeFromDeepSleep |=> timerIrqFlag)
      else $error("irq flag dropped on its own");
   a_wake_clears_all: assert property (wakeFromDeepSleep |=> sfrReadData == 8'h00 && !timerIrqFlag
      && !irqRequest && !expiryDmaTrigger)
      else $error("outputs not cleared after wake");
   a_unmapped_read: assert property (unmappedRead && !wakeFromDeepSleep |=> sfrReadData == 8'h00)
      else $error("unmapped read returned non-zero");
   a_read_data_holds: assert property (!sfrRead && !wakeFromDeepSleep |=> $stable(sfrReadData))
      else $error("read data changed without a read");
   a_prescaler_readback: assert property (prescalerWr ##2 prescalerRd |=> sfrReadData == $past(sfrWriteData, 3))
      else $error("prescaler value read back wrong");
   // bit 6 is left out: hardware may set it between write and read
   a_control_readback: assert property (controlWr ##2 controlRd |=>
      (sfrReadData & 8'hBF) == ($past(sfrWriteData, 3) & 8'h3F))
      else $error("control register read back wrong");

   c_expiry: cover property (expiryDmaTrigger);
   c_irq_request: cover property ($rose(irqRequest));
   c_wake: cover property (wakeFromDeepSleep);
endmodule

bind slot_timer slot_timer_assertions chk_i (.ref_clk(ref_clk), .resetn(resetn), .timerTick(timerTick),
   .wakeFromDeepSleep(wakeFromDeepSleep), .systemIrqEnable(systemIrqEnable), .irqFlagClear(irqFlagClear),
   .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWriteData(sfrWriteData),
   .sfrReadData(sfrReadData), .timerIrqFlag(timerIrqFlag), .irqRequest(irqRequest),
   .expiryDmaTrigger(expiryDmaTrigger));

/* tb/slot_timer_bench.sv */
/*
 * self-checking bench for the slot timer: sfr read and write tasks,
 * then register, expiry, interval, wrap and wake sequences.
 * assumes: timerTick is made here on every second clock cycle.
 */
`timescale 1ns/1ps
module slot_timer_bench;
   // ************************************************************
   // stimulus, observed outputs and bookkeeping
   // ************************************************************
   localparam int CYCLE_LIMIT = 50000; // run needs about 37k cycles
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic timerTick = 1'b0;
   logic wakeFromDeepSleep = 1'b0;
   logic systemIrqEnable = 1'b1;
   logic irqFlagClear = 1'b0;
   logic [7:0] sfrAddr = 8'h00;
   logic sfrWrite = 1'b0;
   logic sfrRead = 1'b0;
   logic [7:0] sfrWriteData = 8'h00;
   logic [7:0] sfrReadData;
   logic timerIrqFlag;
   logic irqRequest;
   logic expiryDmaTrigger;
   logic [7:0] ctl; // control value of the current pass
   logic [7:0] cnt; // start count of the current pass
   int mults[4] = '{slot_timer_pkg::MULT_SEL0, slot_timer_pkg::MULT_SEL1, slot_timer_pkg::MULT_SEL2,
      slot_timer_pkg::MULT_SEL3};
   int nFail = 0;
   int totalChecks = 0;
   int tickCount = 0; // ticks seen by the design so far
   int cycles = 0;

   slot_timer dut (.ref_clk(ref_clk), .resetn(resetn), .timerTick(timerTick),
      .wakeFromDeepSleep(wakeFromDeepSleep), .systemIrqEnable(systemIrqEnable), .irqFlagClear(irqFlagClear),
      .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWriteData(sfrWriteData),
      .sfrReadData(sfrReadData), .timerIrqFlag(timerIrqFlag), .irqRequest(irqRequest),
      .expiryDmaTrigger(expiryDmaTrigger));

   // 50 ns period
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   // tick every second cycle keeps it a one-cycle pulse; also the hang guard
   always @(posedge ref_clk) begin
      timerTick <= ~timerTick;
      tickCount <= tickCount + (timerTick ? 1 : 0);
      cycles <= cycles + 1;
      if (cycles == CYCLE_LIMIT) begin
         $display("timeout at %0t ns", $time);
         nFail++;
         tally_and_finish();
      end
   end

   // ************************************************************
   // tasks: compare, sfr access, expiry wait, verdict
   // ************************************************************
   task chk(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nFail++;
         $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // strobe for one cycle, starting at a rising edge
   task sfr_write(input logic [7:0] addr, input logic [7:0] data);
      sfrAddr <= addr;
      sfrWriteData <= data;
      sfrWrite <= 1'b1;
      @(posedge ref_clk);
      sfrWrite <= 1'b0;
      @(posedge ref_clk);
   endtask

   // read data is registered, so it is sampled half a cycle after the edge
   task rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] got;
      sfrAddr <= addr;
      sfrRead <= 1'b1;
      @(posedge ref_clk);
      sfrRead <= 1'b0;
      @(negedge ref_clk);
      got = sfrReadData;
      @(posedge ref_clk);
      chk(got, exp);
   endtask

   // program and start the timer, then wait for its dma trigger
   task run_expiry(input logic [7:0] pr, input logic [7:0] c, input logic [7:0] n, input int expTicks);
      int start;
      int i;
      sfr_write(slot_timer_pkg::PRESCALER_VALUE_ADDR, pr);
      sfr_write(slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR, c);
      start = tickCount;
      sfr_write(slot_timer_pkg::SLOT_COUNT_ADDR, n);
      i = 0;
      do begin
         @(negedge ref_clk);
         i++;
      end while (expiryDmaTrigger !== 1'b1 && i < 2 * expTicks + 40);
      i = tickCount - start;
      chk({7'h00, expiryDmaTrigger}, 8'h01);
      chk({7'h00, i >= expTicks - 1 && i <= expTicks + 3}, 8'h01);
      @(posedge ref_clk);
   endtask

   task pulse_wake;
      wakeFromDeepSleep <= 1'b1;
      @(posedge ref_clk);
      wakeFromDeepSleep <= 1'b0;
      @(posedge ref_clk);
   endtask

   task tally_and_finish;
      $display("comparisons %0d, mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      // reset values, unmapped read, read-back and refused bit 6
      rd_chk(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h00);
      rd_chk(slot_timer_pkg::PRESCALER_VALUE_ADDR, 8'h00);
      rd_chk(slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR, 8'h00);
      rd_chk(8'h9F, 8'h00);
      sfr_write(slot_timer_pkg::PRESCALER_VALUE_ADDR, 8'hA5);
      rd_chk(slot_timer_pkg::PRESCALER_VALUE_ADDR, 8'hA5);
      sfr_write(slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR, 8'h57);
      rd_chk(slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR, 8'h17);
      sfr_write(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h05);
      rd_chk(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h05);
      pulse_wake();
      rd_chk(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h00);
      rd_chk(slot_timer_pkg::PRESCALER_VALUE_ADDR, 8'h00);
      rd_chk(slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR, 8'h00);
      $display("test registers done");
      // every interval code; odd codes enable the flag, the last one without system enable
      for (int s = 0; s < 4; s++) begin
         ctl = 8'(s) | (s[0] ? 8'h10 : 8'h00);
         cnt = (s == 0) ? 8'h02 : 8'h01;
         systemIrqEnable <= (s != 3);
         run_expiry(8'h01, ctl, cnt, int'(cnt) * mults[s]);
         chk({7'h00, timerIrqFlag}, {7'h00, ctl[4]});
         chk({7'h00, irqRequest}, {7'h00, ctl[4] & (s != 3)});
         rd_chk(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h00);
         rd_chk(slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR, ctl | 8'h40);
         repeat (200) @(posedge ref_clk);
         rd_chk(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h00);
         irqFlagClear <= 1'b1;
         @(posedge ref_clk);
         irqFlagClear <= 1'b0;
         sfr_write(slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR, 8'h00);
         chk({7'h00, timerIrqFlag}, 8'h00);
         rd_chk(slot_timer_pkg::SLOT_TIMER_CONTROL_ADDR, 8'h00);
      end
      $display("test intervals done");
      // prescaler value zero counts as 256
      run_expiry(8'h00, 8'h00, 8'h01, 256 * slot_timer_pkg::MULT_SEL0);
      $display("test zero prescaler done");
      // free-running mode: wrap to 0xFF, then a write landing on a slot edge
      run_expiry(8'h01, 8'h04, 8'h01, slot_timer_pkg::MULT_SEL0);
      repeat (188) @(posedge ref_clk);
      rd_chk(slot_timer_pkg::SLOT_COUNT_ADDR, 8'hFF);
      // slot edges are 128 cycles apart; this write lands on the first edge after the wrap
      repeat (64) @(posedge ref_clk);
      sfr_write(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h10);
      rd_chk(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h0F);
      pulse_wake();
      rd_chk(slot_timer_pkg::SLOT_COUNT_ADDR, 8'h00);
      $display("test wrap and wake done");
      tally_and_finish();
   end
endmodule
